// file: ecp_top.v
// Function
// - Mode zero turns off and resets unit
// - Mode 0010 toggles pin on compare match
// - Capture modes pick falling, rising, 4th, 16th
// - 1000 init low set; 1001 init high clear
// - 1010 sets flag only, pin released
// - 1011 match pulses timer reset, sets flag
// - Compare register acts as capture timer period
// - 11xx selects PWM; low bits set polarity
// - Non-PWM modes: A is capture/compare pin
// - Config 00 modulates A only
// - Config 01: D modulated, A active, B,C inactive
// - Config 10: A,B modulated with dead band
// - Config 11: B modulated, C active, A,D inactive
// - Control bits 5:4 are duty low bits
// - PWM controls load at period boundary
// - Dead band loads at duty or period boundary
// - PWM starts only after period timer reset
// - Period is (period+1)*4*prescale oscillator clocks
// - Period end clears timer, sets output unless duty is zero, copies duty
// - Postscaler only paces separate update flag
// - Capture/compare use 16-bit timers, PWM 8-bit
// - Clear output when duty matches timer+sub bits
// - Duty beyond period never clears output
// - Half bridge: B is complement of A
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ecp_regs.vh"

module ecp_top (
  input wire core_clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire capture_pin_i,
  input wire [15:0] cap_timer_a_i,
  input wire [15:0] cap_timer_b_i,
  output reg pwm_out_a_o,
  output reg pwm_out_b_o,
  output reg pwm_out_c_o,
  output reg pwm_out_d_o,
  output reg pwm_oe_a_o,
  output reg pwm_oe_b_o,
  output reg pwm_oe_c_o,
  output reg pwm_oe_d_o,
  output reg trig_reset_a_o,
  output reg trig_reset_b_o,
  output wire match_flag_o
);

  // Prescaler terminal count for the period timer tick
  function [3:0] psc_lim;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: psc_lim = `ECP_PSC_LIM_1;
        2'h1: psc_lim = `ECP_PSC_LIM_4;
        default: psc_lim = `ECP_PSC_LIM_16;
      endcase
    end
  endfunction

  // Software registers
  reg [7:0] ctrl_ff;
  reg [7:0] duty_ff;
  reg [7:0] per_ff;
  reg [7:0] cmpl_ff;
  reg [7:0] cmph_ff;
  reg [7:0] tcfg_ff;
  reg [6:0] dband_ff;
  reg [1:0] stat_ff;

  // Period timer
  reg [3:0] psc_ff;
  reg [1:0] fine_ff;
  reg [7:0] ptmr_ff;
  reg [3:0] post_ff;

  // PWM shadows and state
  reg [3:0] act_mode_ff;
  reg [1:0] act_cfg_ff;
  reg [7:0] dshd_ff;
  reg [1:0] dlat_ff;
  reg [6:0] db_shd_ff;
  reg pwm_run_ff;
  reg pwm_ff;
  reg pwm_prev_ff;
  reg [6:0] dead_ff;

  // Capture/compare state
  reg ccp_pin_ff;
  reg hit_prev_ff;
  reg cap_prev_ff;
  reg [3:0] cap_cnt_ff;

  wire [3:0] mode = ctrl_ff[`ECP_MODE_MSB:`ECP_MODE_LSB];
  wire unit_off = (mode == `ECP_MODE_OFF);
  wire pwm_mode = (mode[3:2] == 2'h3);
  wire ctrl_wr = reg_wr_i && (reg_addr_i == `ECP_OFF_CTRL);
  wire [3:0] new_mode = reg_wdata_i[`ECP_MODE_MSB:`ECP_MODE_LSB];

  // Period timer tick: one per prescale count of oscillator clocks
  wire tmr_on = tcfg_ff[`ECP_TCFG_ON];
  wire tick = tmr_on && (psc_ff == psc_lim(tcfg_ff[`ECP_TCFG_PSC_MSB:`ECP_TCFG_PSC_LSB]));
  wire period_end = tick && (fine_ff == 2'h3) && (ptmr_ff == per_ff);
  wire [9:0] duty_next = {duty_ff, ctrl_ff[`ECP_DCLO_MSB:`ECP_DCLO_LSB]};
  // Clear on the tick that brings the count to the duty value, so the asserted time is duty times prescale
  wire [9:0] cnt_next = {ptmr_ff, fine_ff} + 10'h001;
  wire duty_hit = tick && ({dshd_ff, dlat_ff} == cnt_next);

  // Selected 16-bit time base for capture and compare
  wire tsel = tcfg_ff[`ECP_TCFG_TSEL];
  wire [15:0] tval = tsel ? cap_timer_b_i : cap_timer_a_i;
  wire is_cmp = (mode == `ECP_MODE_CMP_TGL) || (mode[3:2] == 2'h2);
  wire is_cap = (mode[3:2] == 2'h1);
  wire hit = (tval == {cmph_ff, cmpl_ff});
  wire match_ev = is_cmp && hit && !hit_prev_ff;
  wire cap_rise = capture_pin_i && !cap_prev_ff;
  wire cap_fall = !capture_pin_i && cap_prev_ff;
  wire cap_edge = (mode == `ECP_MODE_CAP_FALL) ? cap_fall : cap_rise;
  reg cap_ev;

  // Capture prescale: every edge, every 4th or every 16th rising edge
  always @* begin
    case (mode)
      `ECP_MODE_CAP_FALL: cap_ev = cap_fall;
      `ECP_MODE_CAP_RISE: cap_ev = cap_rise;
      `ECP_MODE_CAP_4: cap_ev = cap_rise && (cap_cnt_ff[1:0] == 2'h3);
      `ECP_MODE_CAP_16: cap_ev = cap_rise && (cap_cnt_ff == 4'hf);
      default: cap_ev = 1'b0;
    endcase
  end

  // Software registers; a capture loads the value pair over a write
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= `ECP_RST_CTRL;
      duty_ff <= `ECP_RST_DUTY;
      per_ff <= `ECP_RST_PERIOD;
      cmpl_ff <= 8'h00;
      cmph_ff <= 8'h00;
      tcfg_ff <= `ECP_RST_TCFG;
      dband_ff <= `ECP_RST_DBAND;
    end else begin
      if (ctrl_wr)
        ctrl_ff <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `ECP_OFF_DUTY)
        duty_ff <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `ECP_OFF_PERIOD)
        per_ff <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `ECP_OFF_TCFG)
        tcfg_ff <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `ECP_OFF_DBAND)
        dband_ff <= reg_wdata_i[6:0];
      if (cap_ev && !unit_off) begin
        cmpl_ff <= tval[7:0];
        cmph_ff <= tval[15:8];
      end else begin
        if (reg_wr_i && reg_addr_i == `ECP_OFF_CMPL)
          cmpl_ff <= reg_wdata_i;
        if (reg_wr_i && reg_addr_i == `ECP_OFF_CMPH)
          cmph_ff <= reg_wdata_i;
      end
    end
  end

  // Sticky flags: a hardware set wins over a same-cycle clear
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_ff <= 2'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == `ECP_OFF_STAT)
        stat_ff <= stat_ff & ~reg_wdata_i[1:0];
      if (!unit_off && (match_ev || cap_ev))
        stat_ff[`ECP_STAT_MATCH] <= 1'b1;
      if (period_end && post_ff == tcfg_ff[`ECP_TCFG_POST_MSB:`ECP_TCFG_POST_LSB])
        stat_ff[`ECP_STAT_POST] <= 1'b1;
    end
  end

  assign match_flag_o = stat_ff[`ECP_STAT_MATCH];

  // Period timer: prescaler, two sub-cycle bits, 8-bit count, postscaler
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      psc_ff <= 4'h0;
      fine_ff <= 2'h0;
      ptmr_ff <= 8'h00;
      post_ff <= 4'h0;
    end else if (!tmr_on) begin
      psc_ff <= 4'h0;
    end else if (tick) begin
      psc_ff <= 4'h0;
      fine_ff <= fine_ff + 2'h1;
      if (period_end) begin
        ptmr_ff <= 8'h00;
        // Postscaler never touches the period, only its own flag
        if (post_ff == tcfg_ff[`ECP_TCFG_POST_MSB:`ECP_TCFG_POST_LSB])
          post_ff <= 4'h0;
        else
          post_ff <= post_ff + 4'h1;
      end else if (fine_ff == 2'h3) begin
        ptmr_ff <= ptmr_ff + 8'h01;
      end
    end else begin
      psc_ff <= psc_ff + 4'h1;
    end
  end

  // PWM core: mode, output config and duty are shadowed at period end, dead band
  // there and at the duty match; a write that leaves PWM mode stops the pulse at once
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_mode_ff <= 4'h0;
      act_cfg_ff <= 2'h0;
      dshd_ff <= 8'h00;
      dlat_ff <= 2'h0;
      db_shd_ff <= 7'h00;
      pwm_run_ff <= 1'b0;
      pwm_ff <= 1'b0;
    end else if (!pwm_mode) begin
      // Leaving PWM (or mode zero) stops at once and rearms the start
      pwm_run_ff <= 1'b0;
      pwm_ff <= 1'b0;
    end else if (period_end) begin
      act_mode_ff <= mode;
      act_cfg_ff <= ctrl_ff[`ECP_OCFG_MSB:`ECP_OCFG_LSB];
      dshd_ff <= duty_ff;
      dlat_ff <= ctrl_ff[`ECP_DCLO_MSB:`ECP_DCLO_LSB];
      db_shd_ff <= dband_ff;
      pwm_run_ff <= 1'b1;
      pwm_ff <= (duty_next != 10'h000);
    end else if (pwm_run_ff && pwm_ff && duty_hit) begin
      // A duty above the period never matches, so the output stays set
      pwm_ff <= 1'b0;
      db_shd_ff <= dband_ff;
    end
  end

  // Dead band: after each edge both half-bridge outputs idle for the delay
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_prev_ff <= 1'b0;
      dead_ff <= 7'h00;
    end else begin
      pwm_prev_ff <= pwm_ff;
      if (pwm_ff != pwm_prev_ff)
        dead_ff <= (db_shd_ff == 7'h00) ? 7'h00 : db_shd_ff - 7'h01;
      else if (dead_ff != 7'h00)
        dead_ff <= dead_ff - 7'h01;
    end
  end

  // The edge cycle is the first idle one, so a zero delay idles none
  wire db_quiet = (pwm_ff != pwm_prev_ff) ? (db_shd_ff == 7'h00) : (dead_ff == 7'h00);
  wire hb_a = pwm_ff && db_quiet;
  wire hb_b = !pwm_ff && db_quiet;

  // Compare pin state and capture edge tracking
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ccp_pin_ff <= 1'b0;
      hit_prev_ff <= 1'b0;
      cap_prev_ff <= 1'b0;
      cap_cnt_ff <= 4'h0;
    end else if (unit_off) begin
      // Entering a compare mode straight from off still takes its initial level
      ccp_pin_ff <= ctrl_wr && (new_mode == `ECP_MODE_CMP_CLR);
      hit_prev_ff <= 1'b0;
      cap_prev_ff <= capture_pin_i;
      cap_cnt_ff <= 4'h0;
    end else begin
      hit_prev_ff <= hit;
      cap_prev_ff <= capture_pin_i;
      if (ctrl_wr && new_mode == `ECP_MODE_CMP_SET)
        ccp_pin_ff <= 1'b0;
      else if (ctrl_wr && new_mode == `ECP_MODE_CMP_CLR)
        ccp_pin_ff <= 1'b1;
      else if (match_ev && mode == `ECP_MODE_CMP_TGL)
        ccp_pin_ff <= !ccp_pin_ff;
      else if (match_ev && mode == `ECP_MODE_CMP_SET)
        ccp_pin_ff <= 1'b1;
      else if (match_ev && mode == `ECP_MODE_CMP_CLR)
        ccp_pin_ff <= 1'b0;
      // Prescale count restarts whenever the mode is rewritten
      if (ctrl_wr)
        cap_cnt_ff <= 4'h0;
      else if (is_cap && cap_edge)
        cap_cnt_ff <= cap_cnt_ff + 4'h1;
    end
  end

  // Special event: one-cycle reset pulse to the selected 16-bit timer,
  // making the compare value that timer's period
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_reset_a_o <= 1'b0;
      trig_reset_b_o <= 1'b0;
    end else begin
      trig_reset_a_o <= match_ev && (mode == `ECP_MODE_CMP_TRIG) && !tsel;
      trig_reset_b_o <= match_ev && (mode == `ECP_MODE_CMP_TRIG) && tsel;
    end
  end

  // Pin steering: asserted levels and pin ownership per mode
  reg [3:0] lvl;
  reg [3:0] own;
  wire low_ac = act_mode_ff[1];
  wire low_bd = act_mode_ff[0];

  always @* begin
    lvl = 4'h0;
    own = 4'h0;
    if (pwm_run_ff) begin
      case (act_cfg_ff)
        `ECP_OCFG_SINGLE: begin
          lvl = {3'h0, pwm_ff};
          own = 4'h1;
        end
        `ECP_OCFG_FWD: begin
          lvl = {pwm_ff, 3'h1};
          own = 4'hf;
        end
        `ECP_OCFG_HALF: begin
          lvl = {2'h0, hb_b, hb_a};
          own = 4'h3;
        end
        default: begin
          lvl = {1'b0, 1'b1, pwm_ff, 1'b0};
          own = 4'hf;
        end
      endcase
    end else if (is_cmp && mode != `ECP_MODE_CMP_SW) begin
      // Software-only compare leaves the pin to the port
      lvl = {3'h0, ccp_pin_ff};
      own = 4'h1;
    end
  end

  // Registered pins; polarity maps asserted level to pin level
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_out_a_o <= 1'b0;
      pwm_out_b_o <= 1'b0;
      pwm_out_c_o <= 1'b0;
      pwm_out_d_o <= 1'b0;
      pwm_oe_a_o <= 1'b0;
      pwm_oe_b_o <= 1'b0;
      pwm_oe_c_o <= 1'b0;
      pwm_oe_d_o <= 1'b0;
    end else begin
      pwm_out_a_o <= lvl[0] ^ (pwm_run_ff && low_ac);
      pwm_out_b_o <= lvl[1] ^ (pwm_run_ff && low_bd);
      pwm_out_c_o <= lvl[2] ^ (pwm_run_ff && low_ac);
      pwm_out_d_o <= lvl[3] ^ (pwm_run_ff && low_bd);
      // Enables only say the unit owns the pin; direction is software's
      pwm_oe_a_o <= own[0];
      pwm_oe_b_o <= own[1];
      pwm_oe_c_o <= own[2];
      pwm_oe_d_o <= own[3];
    end
  end

  // Read port: data one cycle after the strobe, zero elsewhere
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `ECP_OFF_CTRL: reg_rdata_o <= ctrl_ff;
        `ECP_OFF_DUTY: reg_rdata_o <= duty_ff;
        `ECP_OFF_PERIOD: reg_rdata_o <= per_ff;
        `ECP_OFF_CMPL: reg_rdata_o <= cmpl_ff;
        `ECP_OFF_CMPH: reg_rdata_o <= cmph_ff;
        `ECP_OFF_TCFG: reg_rdata_o <= tcfg_ff;
        `ECP_OFF_STAT: reg_rdata_o <= {6'h00, stat_ff};
        `ECP_OFF_DBAND: reg_rdata_o <= {1'b0, dband_ff};
        `ECP_OFF_PTMR: reg_rdata_o <= ptmr_ff;
        `ECP_OFF_DSHD: reg_rdata_o <= dshd_ff;
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule // ecp_top

`default_nettype wire

// file: ecp_regs.vh
`ifndef ECP_REGS_VH
`define ECP_REGS_VH

// Register byte offsets
`define ECP_OFF_CTRL 8'h00
`define ECP_OFF_DUTY 8'h04
`define ECP_OFF_PERIOD 8'h08
`define ECP_OFF_CMPL 8'h0c
`define ECP_OFF_CMPH 8'h10
`define ECP_OFF_TCFG 8'h14
`define ECP_OFF_STAT 8'h18
`define ECP_OFF_DBAND 8'h1c
`define ECP_OFF_PTMR 8'h20
`define ECP_OFF_DSHD 8'h24

// Control register fields
`define ECP_MODE_MSB 3
`define ECP_MODE_LSB 0
`define ECP_DCLO_MSB 5
`define ECP_DCLO_LSB 4
`define ECP_OCFG_MSB 7
`define ECP_OCFG_LSB 6

// Timer configuration fields
`define ECP_TCFG_PSC_MSB 1
`define ECP_TCFG_PSC_LSB 0
`define ECP_TCFG_ON 2
`define ECP_TCFG_POST_MSB 6
`define ECP_TCFG_POST_LSB 3
`define ECP_TCFG_TSEL 7

// Status fields
`define ECP_STAT_MATCH 0
`define ECP_STAT_POST 1

// Mode selector codes
`define ECP_MODE_OFF 4'h0
`define ECP_MODE_CMP_TGL 4'h2
`define ECP_MODE_CAP_FALL 4'h4
`define ECP_MODE_CAP_RISE 4'h5
`define ECP_MODE_CAP_4 4'h6
`define ECP_MODE_CAP_16 4'h7
`define ECP_MODE_CMP_SET 4'h8
`define ECP_MODE_CMP_CLR 4'h9
`define ECP_MODE_CMP_SW 4'ha
`define ECP_MODE_CMP_TRIG 4'hb

// Output configurations
`define ECP_OCFG_SINGLE 2'h0
`define ECP_OCFG_FWD 2'h1
`define ECP_OCFG_HALF 2'h2
`define ECP_OCFG_REV 2'h3

// Reset values
`define ECP_RST_CTRL 8'h00
`define ECP_RST_DUTY 8'h00
`define ECP_RST_PERIOD 8'hff
`define ECP_RST_TCFG 8'h00
`define ECP_RST_DBAND 7'h00

// Timing: oscillator period and sub-cycle clocks per instruction cycle
`define ECP_TOSC_NS 20
`define ECP_Q_PER_INSTR 4
`define ECP_PSC_LIM_1 4'h0
`define ECP_PSC_LIM_4 4'h3
`define ECP_PSC_LIM_16 4'hf

`endif

// file: ecp_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "ecp_regs.vh"
module ecp_top_sva (
  input wire core_clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire pwm_oe_a_o,
  input wire pwm_oe_b_o,
  input wire pwm_oe_c_o,
  input wire pwm_oe_d_o,
  input wire trig_reset_a_o,
  input wire trig_reset_b_o,
  input wire match_flag_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // Mode zero written, then a cycle without a write
  sequence s_off_wr;
    reg_wr_i && reg_addr_i == `ECP_OFF_CTRL && reg_wdata_i[3:0] == 4'h0 ##1 !reg_wr_i;
  endsequence
  sequence s_trig;
    trig_reset_a_o || trig_reset_b_o;
  endsequence
  chk_off_release: assert property (s_off_wr |-> ##2 {pwm_oe_a_o, pwm_oe_b_o, pwm_oe_c_o, pwm_oe_d_o} == 4'h0)
    else $error("pins still owned after mode zero");
  // Read data stands only in the cycle after the strobe
  chk_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
  chk_trig_pulse: assert property (s_trig |=> !trig_reset_a_o && !trig_reset_b_o)
    else $error("timer reset longer than one cycle");
  chk_trig_flag: assert property (s_trig |-> match_flag_o)
    else $error("timer reset without match flag");
  chk_trig_single: assert property (!(trig_reset_a_o && trig_reset_b_o))
    else $error("both timers reset at once");
  // Pin ownership follows the steering table
  chk_quad_pair: assert property (pwm_oe_c_o == pwm_oe_d_o)
    else $error("outputs c and d owned apart");
  chk_quad_has_b: assert property (pwm_oe_c_o |-> pwm_oe_b_o)
    else $error("full bridge without output b");
  chk_needs_a: assert property ((pwm_oe_b_o || pwm_oe_c_o) |-> pwm_oe_a_o)
    else $error("outputs b to d owned without a");
  // Sticky flag falls only by a write of one
  chk_flag_clear: assert property ($fell(match_flag_o) |-> $past(reg_wr_i && reg_addr_i == `ECP_OFF_STAT && reg_wdata_i[0]))
    else $error("match flag dropped without clear");
endmodule // ecp_top_sva
bind ecp_top ecp_top_sva ecp_top_sva_inst (
  .core_clk_i,
  .rst_i,
  .reg_addr_i,
  .reg_wdata_i,
  .reg_wr_i,
  .reg_rd_i,
  .reg_rdata_o,
  .pwm_oe_a_o,
  .pwm_oe_b_o,
  .pwm_oe_c_o,
  .pwm_oe_d_o,
  .trig_reset_a_o,
  .trig_reset_b_o,
  .match_flag_o
);
`default_nettype wire

// file: ecp_load_model.sv
`timescale 1ns/100ps
`default_nettype none
module ecp_load_model (
  input wire logic clk_i,
  input wire logic [3:0] out_i,
  input wire logic [3:0] oe_i,
  input wire logic [3:0] port_dir_i,
  output logic [3:0] pin_o
);
  logic [3:0] idle_ff = 4'h5;
  // Port-held pins flip each cycle so a stale level never passes for a driven one
  always @(posedge clk_i) begin
    idle_ff <= ~idle_ff;
  end
  // The load sees the unit only where software made the port an output
  assign pin_o = (oe_i & port_dir_i & out_i) | (~(oe_i & port_dir_i) & idle_ff);
endmodule // ecp_load_model
`default_nettype wire

// file: ecp_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ecp_regs.vh"
module ecp_top_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic cap_pin = 1'b0;
  logic clr_t = 1'b0;
  logic watch = 1'b0;
  logic primed = 1'b0;
  logic [15:0] tmr_a = 16'h0000;
  logic [15:0] tmr_b = 16'h0000;
  logic [31:0] lfsr = 32'h7fb9cf95;
  wire [7:0] rdata;
  wire [3:0] out;
  wire [3:0] oe;
  wire [3:0] pin;
  wire trig_a;
  wire trig_b;
  wire flag;
  logic [7:0] q_rd[$];
  int q_w[$];
  int n_errors = 0;
  int cmp_count = 0;
  int n_trig = 0;
  int n_trig_b = 0;
  int hi_run = 0;
  int sel = 0;
  int edges[4] = '{1, 1, 4, 16};
  logic [3:0] cm[6] = '{4'h8, 4'h9, 4'ha, 4'h2, 4'hb, 4'hb};
  // PWM cases: control, watched pin, high width, owned pins, steady mask and levels
  logic [7:0] pc[6] = '{8'h3c, 8'h3e, 8'h7c, 8'hbc, 8'hfc, 8'h7f};
  int ps[6] = '{0, 0, 3, 1, 1, 3};
  int pw[6] = '{11, 9, 11, 9, 11, 9};
  logic [3:0] po[6] = '{4'h1, 4'h1, 4'hf, 4'h3, 4'hf, 4'hf};
  logic [3:0] pm[6] = '{4'h0, 4'h0, 4'h7, 4'h0, 4'hd, 4'h7};
  logic [3:0] pv[6] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h4, 4'h6};
  always #10 core_clk_i = ~core_clk_i;
  ecp_top ecp_top_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .capture_pin_i(cap_pin), .cap_timer_a_i(tmr_a),
    .cap_timer_b_i(tmr_b), .pwm_out_a_o(out[0]), .pwm_out_b_o(out[1]), .pwm_out_c_o(out[2]),
    .pwm_out_d_o(out[3]), .pwm_oe_a_o(oe[0]), .pwm_oe_b_o(oe[1]), .pwm_oe_c_o(oe[2]), .pwm_oe_d_o(oe[3]),
    .trig_reset_a_o(trig_a), .trig_reset_b_o(trig_b), .match_flag_o(flag));
  ecp_load_model ecp_load_model_inst (.clk_i(core_clk_i), .out_i(out), .oe_i(oe), .port_dir_i(4'hf), .pin_o(pin));
  function automatic logic [31:0] nxt_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // One strobe cycle, then an idle cycle so a strobe is never set twice at one edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    cyc(1);
    wr <= 1'b0;
    rd <= 1'b0;
    cyc(1);
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    q_rd.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  // Reset the unit, clear status, enter a mode, restart both timers
  task automatic arm(input logic [7:0] m);
    bus(1'b1, `ECP_OFF_CTRL, 8'h00);
    bus(1'b1, `ECP_OFF_STAT, 8'h03);
    bus(1'b1, `ECP_OFF_CTRL, m);
    clr_t <= 1'b1;
    cyc(1);
    clr_t <= 1'b0;
  endtask
  task automatic pulse;
    cap_pin <= 1'b1;
    cyc(3);
    cap_pin <= 1'b0;
    cyc(3);
  endtask
  task automatic drain;
    int n;
    for (n = 0; n < 600 && q_w.size() > 0; n++) @(posedge core_clk_i);
    if (q_w.size() > 0) begin
      n_errors++;
      $display("FAIL width queue expected 0 seen %0d", q_w.size());
      tally_and_finish;
    end
  endtask
  // External capture timers free-run and restart on the unit's trigger
  always @(posedge core_clk_i) begin
    tmr_a <= (trig_a || clr_t) ? 16'h0000 : tmr_a + 16'h0001;
    tmr_b <= (trig_b || clr_t) ? 16'h0000 : tmr_b + 16'h0001;
    n_trig <= n_trig + (trig_a === 1'b1);
    n_trig_b <= n_trig_b + (trig_b === 1'b1);
  end
  // Results are set against the oldest note as they appear; width is a high run on the watched pin
  always @(posedge core_clk_i) begin
    rd_seen <= rd;
    if (rd_seen) chk("rdata", q_rd.pop_front(), rdata);
    if (!watch) begin
      hi_run <= 0;
      primed <= 1'b0;
    end else if (pin[sel] === 1'b1) hi_run <= hi_run + 1;
    else if (hi_run > 0) begin
      if (primed && q_w.size() > 0) chk("width", 8'(q_w.pop_front()), 8'(hi_run));
      primed <= 1'b1;
      hi_run <= 0;
    end
  end
  initial begin
    int i;
    int n;
    int ta;
    int tb0;
    logic [1:0] lv;
    cyc(12);
    rst_i <= 1'b0;
    cyc(1);
    rd_exp(`ECP_OFF_CTRL, 8'h00);
    rd_exp(`ECP_OFF_DUTY, 8'h00);
    rd_exp(`ECP_OFF_PERIOD, 8'hff);
    rd_exp(`ECP_OFF_TCFG, 8'h00);
    rd_exp(`ECP_OFF_DBAND, 8'h00);
    rd_exp(8'hfc, 8'h00);
    for (i = 0; i < 3; i++) begin
      lfsr = nxt_lfsr(lfsr);
      bus(1'b1, `ECP_OFF_DUTY, lfsr[7:0]);
      rd_exp(`ECP_OFF_DUTY, lfsr[7:0]);
    end
    $display("test registers done");
    // The flag rises only on the edge that completes the chosen count
    for (i = 0; i < 4; i++) begin
      arm(8'h04 + 8'(i));
      repeat (edges[i] - 1) pulse;
      rd_exp(`ECP_OFF_STAT, 8'h00);
      pulse;
      rd_exp(`ECP_OFF_STAT, 8'h01);
      chk("match_flag", 8'h01, {7'h00, flag});
    end
    $display("test capture done");
    bus(1'b1, `ECP_OFF_CMPL, 8'h30);
    bus(1'b1, `ECP_OFF_CMPH, 8'h00);
    // Compare match at timer 48 inside a 64 cycle window
    for (i = 0; i < 6; i++) begin
      bus(1'b1, `ECP_OFF_TCFG, i == 5 ? 8'h80 : 8'h00);
      arm({4'h0, cm[i]});
      cyc(4);
      lv = {oe[0], out[0]};
      ta = n_trig;
      tb0 = n_trig_b;
      cyc(60);
      rd_exp(`ECP_OFF_STAT, 8'h01);
      case (i)
        0, 1: chk("cmp_pin", i ? 8'h0e : 8'h0b, {4'h0, lv, oe[0], out[0]});
        2: chk("cmp_oe", 8'h00, {6'h00, lv[1], oe[0]});
        3: chk("cmp_tgl", 8'h03, {6'h00, lv[1], out[0] ^ lv[0]});
        default: chk("trig_sel", i == 4 ? 8'h01 : 8'h02, {6'h00, n_trig_b != tb0, n_trig != ta});
      endcase
    end
    $display("test compare done");
    // Period 20 cycles, duty 11 cycles, prescale 1
    bus(1'b1, `ECP_OFF_PERIOD, 8'h04);
    bus(1'b1, `ECP_OFF_DUTY, 8'h02);
    bus(1'b1, `ECP_OFF_TCFG, 8'h04);
    for (i = 0; i < 6; i++) begin
      bus(1'b1, `ECP_OFF_CTRL, pc[i]);
      cyc(50);
      sel <= ps[i];
      chk("oe", {4'h0, po[i]}, {4'h0, oe});
      chk("steady", {4'h0, pv[i]}, {4'h0, pin & pm[i]});
      watch <= 1'b1;
      q_w.push_back(pw[i]);
      q_w.push_back(pw[i]);
      drain;
      watch <= 1'b0;
    end
    // Half bridge with a three cycle dead band: output a keeps 8 of its 11 cycles
    bus(1'b1, `ECP_OFF_DBAND, 8'h03);
    bus(1'b1, `ECP_OFF_CTRL, 8'hbc);
    cyc(50);
    sel <= 0;
    watch <= 1'b1;
    q_w.push_back(8);
    q_w.push_back(8);
    drain;
    watch <= 1'b0;
    // Duty beyond the period never clears; zero duty never sets
    for (i = 0; i < 2; i++) begin
      bus(1'b1, `ECP_OFF_DUTY, i ? 8'h00 : 8'hff);
      bus(1'b1, `ECP_OFF_CTRL, i ? 8'h0c : 8'h3c);
      cyc(50);
      n = 0;
      repeat (40) begin
        @(posedge core_clk_i);
        n += (out[0] !== (i == 0));
      end
      chk("flat", 8'h00, 8'(n));
    end
    // Prescale 4 stretches duty to 44 cycles in an 80 cycle period
    bus(1'b1, `ECP_OFF_TCFG, 8'h05);
    bus(1'b1, `ECP_OFF_DUTY, 8'h02);
    bus(1'b1, `ECP_OFF_CTRL, 8'h3c);
    cyc(200);
    sel <= 0;
    watch <= 1'b1;
    q_w.push_back(44);
    drain;
    watch <= 1'b0;
    bus(1'b1, `ECP_OFF_CTRL, 8'h00);
    cyc(3);
    chk("off", 8'h00, {oe, out});
    $display("test pwm done");
    tally_and_finish;
  end
endmodule // ecp_top_tb_top
`default_nettype wire
